// >>> verilog/led_diag_pkg.sv
// Register map, field positions and timing constants of the diagnostic bank
package led_diag_pkg;
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned DATA_W          = 16;

    // Register offsets (byte addresses on the serial control bus)
    localparam logic [7:0]  OFS_LED_FAULT   = 8'h12;
    localparam logic [7:0]  OFS_STATE_DIAG  = 8'h14;
    localparam logic [7:0]  OFS_PWM_IN_DIAG = 8'h16;
    localparam logic [7:0]  OFS_PWM_OUT_DIAG = 8'h18;

    // Field positions of the LED fault register
    localparam int unsigned BIT_TIMEOUT_FLAG = 14;
    localparam int unsigned BIT_TIMEOUT_CLR  = 13;
    localparam int unsigned BIT_BADCFG_FLAG  = 12;
    localparam int unsigned BIT_BADCFG_CLR   = 11;
    localparam int unsigned BIT_SUMMARY_FLAG = 10;
    localparam int unsigned BIT_SUMMARY_CLR  = 9;
    localparam int unsigned BIT_GROUNDED     = 8;
    localparam int unsigned BIT_SHORTED      = 7;
    localparam int unsigned BIT_OPEN         = 6;
    localparam int unsigned BIT_CHAN_LSB     = 0;
    localparam int unsigned NUM_CHAN         = 4;

    // State diagnostic field
    localparam int unsigned STATE_W          = 5;

    // Reset values
    localparam logic [15:0] RESET_WORD       = 16'h0000;

    // Live state codes reported by the functional state machine
    localparam logic [4:0]  ST_DISABLED      = 5'h00;
    localparam logic [4:0]  ST_REG_STARTUP   = 5'h01;
    localparam logic [4:0]  ST_OTP_READ      = 5'h02;
    localparam logic [4:0]  ST_STANDBY       = 5'h03;
    localparam logic [4:0]  ST_BOOST_FIRST   = 5'h04;
    localparam logic [4:0]  ST_BOOST_LAST    = 5'h0f;
    localparam logic [4:0]  ST_NORMAL        = 5'h10;
    localparam logic [4:0]  ST_SHUTDOWN      = 5'h11;
    localparam logic [4:0]  ST_FAULT_RECOV   = 5'h12;
    localparam logic [4:0]  ST_ALL_LED_FAULT = 5'h13;

    // Duty measurement window: 2**16 cycles of 100 ns
    localparam int unsigned DUTY_W           = 16;
    localparam int unsigned WINDOW_LOG2_DEF  = 16;
endpackage : led_diag_pkg

// >>> verilog/led_diag_status_regs.sv
// Diagnostic and fault status register bank of the LED driver
// Overview of operation
// RULE1 - Bus timeout event sets latched flag at bit 14; zero otherwise.
// RULE2 - Flag clears only when host writes 1 to flag and paired clear together.
// RULE3 - Invalid string arrangement sets flag at bit 12, cleared via bit 11.
// RULE4 - Any open, internal short or grounded LED fault sets flag at bit 10.
// RULE5 - Bit 8 is a read-only live LED short-to-ground indicator.
// RULE6 - Bit 7 internal short indicator clears together with summary flag.
// RULE7 - Bit 6 open indicator clears together with summary flag.
// RULE8 - Host writes zero to reserved bits 5 and 4.
// RULE9 - Bits 3..0 show live per-channel faults, channel four highest.
// RULE10 - Live five-bit state machine code readable in state register.
// RULE11 - State register bits 15..5 read zero.
// RULE12 - Incoming PWM duty cycle measured, read as full 16-bit register.
// RULE13 - Configured PWM output duty readable, resets to zero.
`timescale 1ns/10ps
`default_nettype none
module led_diag_status_regs
    import led_diag_pkg::*;
#(
    parameter int unsigned WINDOW_LOG2 = led_diag_pkg::WINDOW_LOG2_DEF
)(
    input  wire logic                           sys_clk,      // 10 MHz clock
    input  wire logic                           resetn,       // Sync reset
    input  wire logic [led_diag_pkg::ADDR_W-1:0] reg_addr,    // Reg offset
    input  wire logic                           reg_wr_en,    // Write strobe
    input  wire logic [led_diag_pkg::DATA_W-1:0] reg_wr_data, // Write word
    input  wire logic                           reg_rd_en,    // Read strobe
    output logic      [led_diag_pkg::DATA_W-1:0] reg_rd_data, // Read word
    input  wire logic                           bus_timeout_evt, // Pulse
    input  wire logic                           bad_string_cfg,  // Level
    input  wire logic                           string_open_det, // Level
    input  wire logic                           string_short_det, // Level
    input  wire logic                           string_gnd_det,  // Level
    input  wire logic [led_diag_pkg::NUM_CHAN-1:0] chan_fault,   // Per chan
    input  wire logic [led_diag_pkg::STATE_W-1:0]  live_state_code, // FSM
    input  wire logic [led_diag_pkg::DUTY_W-1:0]   pwm_out_duty_cfg, // Cfg
    input  wire logic                           pwm_dim_in,   // Async pin
    output logic                                fault_pending // Pin level
);
    import led_diag_pkg::*;

    // Latched flags
    logic timeout_flag_reg, timeout_flag_next;
    logic badcfg_flag_reg,  badcfg_flag_next;
    logic summary_flag_reg, summary_flag_next;
    logic shorted_ind_reg,  shorted_ind_next;
    logic open_ind_reg,     open_ind_next;
    // Live snapshots
    logic                grounded_ind_reg, grounded_ind_next;
    logic [NUM_CHAN-1:0] chan_fault_reg,   chan_fault_next;
    logic [STATE_W-1:0]  state_code_reg,   state_code_next;
    logic [DUTY_W-1:0]   pwm_out_duty_reg, pwm_out_duty_next;
    // PWM input measurement
    logic                pwm_sync1_reg, pwm_sync1_next;
    logic                pwm_sync2_reg, pwm_sync2_next;
    logic [WINDOW_LOG2-1:0] win_cnt_reg, win_cnt_next;
    logic [WINDOW_LOG2:0]   high_cnt_reg, high_cnt_next;
    logic [DUTY_W-1:0]   pwm_in_duty_reg, pwm_in_duty_next;
    // Bus answer
    logic [DATA_W-1:0]   rd_data_reg, rd_data_next;
    logic                pending_reg, pending_next;

    logic fault_wr;

    // Paired clear: both the flag bit and its clear bit written as 1
    function automatic logic pair_clear(input logic [DATA_W-1:0] w,
                                        input int unsigned fb,
                                        input int unsigned cb);
        pair_clear = w[fb] & w[cb];
    endfunction : pair_clear

    // Scale high-sample count of the window to a 16-bit duty value
    function automatic logic [DUTY_W-1:0] scale_duty(
        input logic [WINDOW_LOG2:0] cnt);
        logic [WINDOW_LOG2+DUTY_W:0] wide;
        wide = {{DUTY_W{1'b0}}, cnt} << DUTY_W;
        wide = wide >> WINDOW_LOG2;
        if (wide > {{(WINDOW_LOG2+1){1'b0}}, {DUTY_W{1'b1}}})
            scale_duty = {DUTY_W{1'b1}};
        else
            scale_duty = wide[DUTY_W-1:0];
    endfunction : scale_duty

    assign fault_wr = reg_wr_en & (reg_addr == OFS_LED_FAULT);

    // Flag group: set wins over a clear in the same cycle
    always_comb
    begin
        timeout_flag_next = timeout_flag_reg;
        badcfg_flag_next  = badcfg_flag_reg;
        summary_flag_next = summary_flag_reg;
        shorted_ind_next  = shorted_ind_reg;
        open_ind_next     = open_ind_reg;
        if (fault_wr)
        begin
            // Bits 5 and 4 and the read-only fields are ignored on write [RULE8]
            if (pair_clear(reg_wr_data, BIT_TIMEOUT_FLAG, BIT_TIMEOUT_CLR))
                timeout_flag_next = 1'b0;                     // [RULE2]
            if (pair_clear(reg_wr_data, BIT_BADCFG_FLAG, BIT_BADCFG_CLR))
                badcfg_flag_next = 1'b0;                      // [RULE2] [RULE3]
            if (pair_clear(reg_wr_data, BIT_SUMMARY_FLAG, BIT_SUMMARY_CLR))
            begin
                summary_flag_next = 1'b0;                     // [RULE2]
                shorted_ind_next  = 1'b0;                     // [RULE6]
                open_ind_next     = 1'b0;                     // [RULE7]
            end
        end
        if (bus_timeout_evt)
            timeout_flag_next = 1'b1;                         // [RULE1]
        if (bad_string_cfg)
            badcfg_flag_next = 1'b1;                          // [RULE3]
        if (string_open_det | string_short_det | string_gnd_det)
            summary_flag_next = 1'b1;                         // [RULE4]
        if (string_short_det)
            shorted_ind_next = 1'b1;                          // [RULE6]
        if (string_open_det)
            open_ind_next = 1'b1;                             // [RULE7]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            timeout_flag_reg <= 1'b0;
            badcfg_flag_reg  <= 1'b0;
            summary_flag_reg <= 1'b0;
            shorted_ind_reg  <= 1'b0;
            open_ind_reg     <= 1'b0;
        end
        else
        begin
            timeout_flag_reg <= timeout_flag_next;
            badcfg_flag_reg  <= badcfg_flag_next;
            summary_flag_reg <= summary_flag_next;
            shorted_ind_reg  <= shorted_ind_next;
            open_ind_reg     <= open_ind_next;
        end
    end

    // Live snapshot group
    always_comb
    begin
        grounded_ind_next = string_gnd_det;                   // [RULE5]
        chan_fault_next   = chan_fault;                       // [RULE9]
        state_code_next   = live_state_code;                  // [RULE10]
        pwm_out_duty_next = pwm_out_duty_cfg;                 // [RULE13]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            grounded_ind_reg <= 1'b0;
            chan_fault_reg   <= '0;
            state_code_reg   <= ST_DISABLED;
            pwm_out_duty_reg <= RESET_WORD;                   // [RULE13]
        end
        else
        begin
            grounded_ind_reg <= grounded_ind_next;
            chan_fault_reg   <= chan_fault_next;
            state_code_reg   <= state_code_next;
            pwm_out_duty_reg <= pwm_out_duty_next;
        end
    end

    // Duty measurement: count high samples over a fixed window.
    // A fixed window avoids a divider; low PWM rates need the window to
    // span several periods, otherwise the value jitters with phase.
    always_comb
    begin
        pwm_sync1_next   = pwm_dim_in;
        pwm_sync2_next   = pwm_sync1_reg;
        win_cnt_next     = win_cnt_reg + 1'b1;
        high_cnt_next    = high_cnt_reg + {{WINDOW_LOG2{1'b0}}, pwm_sync2_reg};
        pwm_in_duty_next = pwm_in_duty_reg;
        if (win_cnt_reg == {WINDOW_LOG2{1'b1}})
        begin
            pwm_in_duty_next = scale_duty(high_cnt_next);     // [RULE12]
            high_cnt_next    = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            pwm_sync1_reg   <= 1'b0;
            pwm_sync2_reg   <= 1'b0;
            win_cnt_reg     <= '0;
            high_cnt_reg    <= '0;
            pwm_in_duty_reg <= RESET_WORD;
        end
        else
        begin
            pwm_sync1_reg   <= pwm_sync1_next;
            pwm_sync2_reg   <= pwm_sync2_next;
            win_cnt_reg     <= win_cnt_next;
            high_cnt_reg    <= high_cnt_next;
            pwm_in_duty_reg <= pwm_in_duty_next;
        end
    end

    // Read path and pending-fault pin
    always_comb
    begin
        rd_data_next = rd_data_reg;
        if (reg_rd_en)
        begin
            rd_data_next = RESET_WORD;
            unique case (reg_addr)
                OFS_LED_FAULT:
                begin
                    rd_data_next[BIT_TIMEOUT_FLAG] = timeout_flag_reg;   // [RULE1]
                    rd_data_next[BIT_BADCFG_FLAG]  = badcfg_flag_reg;    // [RULE3]
                    rd_data_next[BIT_SUMMARY_FLAG] = summary_flag_reg;   // [RULE4]
                    rd_data_next[BIT_GROUNDED]     = grounded_ind_reg;   // [RULE5]
                    rd_data_next[BIT_SHORTED]      = shorted_ind_reg;    // [RULE6]
                    rd_data_next[BIT_OPEN]         = open_ind_reg;       // [RULE7]
                    rd_data_next[BIT_CHAN_LSB +: NUM_CHAN] = chan_fault_reg; // [RULE9]
                end
                OFS_STATE_DIAG:
                    rd_data_next[STATE_W-1:0] = state_code_reg;  // [RULE10] [RULE11]
                OFS_PWM_IN_DIAG:
                    rd_data_next = pwm_in_duty_reg;              // [RULE12]
                OFS_PWM_OUT_DIAG:
                    rd_data_next = pwm_out_duty_reg;             // [RULE13]
                default:
                    rd_data_next = RESET_WORD;
            endcase
        end
        // Pin follows the latched flags, so it drops with the paired clear
        pending_next = timeout_flag_next | badcfg_flag_next
                     | summary_flag_next;                         // [RULE2]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rd_data_reg <= RESET_WORD;
            pending_reg <= 1'b0;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
            pending_reg <= pending_next;
        end
    end

    assign reg_rd_data   = rd_data_reg;
    assign fault_pending = pending_reg;
endmodule : led_diag_status_regs
`default_nettype wire

// >>> verification/led_diag_checker.sv
// Port-level assertions for the diagnostic register bank
`timescale 1ns/10ps
`default_nettype none
module led_diag_checker
    import led_diag_pkg::*;
(
    input wire logic        sys_clk,          // Clock
    input wire logic        resetn,           // Sync reset
    input wire logic [7:0]  reg_addr,         // Offset
    input wire logic        reg_wr_en,        // Write strobe
    input wire logic [15:0] reg_wr_data,      // Write word
    input wire logic        reg_rd_en,        // Read strobe
    input wire logic [15:0] reg_rd_data,      // Read word
    input wire logic        bus_timeout_evt,  // Event
    input wire logic        bad_string_cfg,   // Level
    input wire logic        string_open_det,  // Level
    input wire logic        string_short_det, // Level
    input wire logic        string_gnd_det,   // Level
    input wire logic [3:0]  chan_fault,       // Per channel
    input wire logic [4:0]  live_state_code,  // State code
    input wire logic        fault_pending     // Pin
);
    logic rd12, pair_wr, any_evt;
    assign rd12 = reg_rd_en && !reg_wr_en && reg_addr == OFS_LED_FAULT;
    assign pair_wr = reg_wr_en && reg_addr == OFS_LED_FAULT &&
        (&reg_wr_data[14:13] || &reg_wr_data[12:11] || &reg_wr_data[10:9]);
    assign any_evt = bus_timeout_evt | bad_string_cfg | string_open_det |
        string_short_det | string_gnd_det;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Live fields lag one cycle, so only stable inputs give a fixed answer
    state_read_a: assert property ($past(resetn) &&
        reg_rd_en && reg_addr == OFS_STATE_DIAG && $stable(live_state_code)
        |=> reg_rd_data == {11'h0, $past(live_state_code)}) else $error("state word wrong");
    live_ind_a: assert property ($past(resetn) && rd12 &&
        $stable({string_gnd_det, chan_fault}) |=> {reg_rd_data[8],
        reg_rd_data[3:0]} == $past({string_gnd_det, chan_fault})) else $error("live bits wrong");
    pend_set_a: assert property (
        any_evt ##1 !pair_wr |-> ##[0:1] fault_pending) else $error("pin not raised");
    pend_clr_a: assert property ($fell(fault_pending) |->
        $past(pair_wr) || $past(pair_wr, 2) || $past(pair_wr, 3)) else $error("pin dropped");
    tmo_read_a: assert property (
        bus_timeout_evt ##1 rd12 |=> reg_rd_data[14]) else $error("timeout flag clear");
    cfg_read_a: assert property (
        bad_string_cfg ##1 rd12 |=> reg_rd_data[12]) else $error("config flag clear");
    open_read_a: assert property (
        string_open_det ##1 rd12 |=> &reg_rd_data[10 -: 5] || (reg_rd_data[10] && reg_rd_data[6])) else $error("open flags clear");
    short_read_a: assert property (
        string_short_det ##1 rd12 |=> reg_rd_data[10] && reg_rd_data[7]) else $error("short flags clear");
endmodule : led_diag_checker
bind led_diag_status_regs led_diag_checker led_diag_checker_inst (
    .sys_clk, .resetn, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
    .reg_rd_data, .bus_timeout_evt, .bad_string_cfg, .string_open_det,
    .string_short_det, .string_gnd_det, .chan_fault, .live_state_code,
    .fault_pending);
`default_nettype wire

// >>> verification/host_model.sv
// Host controller model issuing register strobes
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic        sys_clk,     // Clock
    input  wire logic [15:0] reg_rd_data, // Read word
    output logic      [7:0]  reg_addr,    // Offset
    output logic             reg_wr_en,   // Write strobe
    output logic      [15:0] reg_wr_data, // Write word
    output logic             reg_rd_en    // Read strobe
);
    initial {reg_addr, reg_wr_en, reg_wr_data, reg_rd_en} = '0;
    // Released lines are scrambled so stale values cannot pass for live ones
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wr_data = d & 16'hffcf;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~reg_wr_data;
    endtask : write
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        @(negedge sys_clk);
        d = reg_rd_data;
    endtask : read
endmodule : host_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the diagnostic register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import led_diag_pkg::*;
    localparam int WL = 6;
    logic        sys_clk, resetn, tmo, bad, opn, sht, gnd, pwm, pend;
    logic        rd_en, wr_en;
    logic [7:0]  addr;
    logic [15:0] wdat, rdat, cfg, got, fb, pb;
    logic [3:0]  chan;
    logic [4:0]  st;
    int          num_errors, num_checks, seed, i, k;
    logic [15:0] fbt [5] = '{16'h4000, 16'h1000, 16'h0440, 16'h0480, 16'h0400};
    logic [15:0] pbt [5] = '{16'h6000, 16'h1800, 16'h0600, 16'h0600, 16'h0600};
    logic [7:0]  adt [6] = '{8'h12, 8'h14, 8'h16, 8'h18, 8'h13, 8'hff};
    led_diag_status_regs #(.WINDOW_LOG2(WL)) led_diag_status_regs_inst (
        .sys_clk, .resetn, .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wr_data(wdat), .reg_rd_en(rd_en), .reg_rd_data(rdat),
        .bus_timeout_evt(tmo), .bad_string_cfg(bad), .string_open_det(opn),
        .string_short_det(sht), .string_gnd_det(gnd), .chan_fault(chan),
        .live_state_code(st), .pwm_out_duty_cfg(cfg), .pwm_dim_in(pwm),
        .fault_pending(pend));
    host_model host_model_inst (.sys_clk, .reg_rd_data(rdat), .reg_addr(addr),
        .reg_wr_en(wr_en), .reg_wr_data(wdat), .reg_rd_en(rd_en));
    // High samples per window times the scale step, saturating at full scale
    function automatic logic [15:0] duty_exp(input int k);
        int h;
        h = k * (1 << (WL - 2)) * (1 << (16 - WL));
        return (h > 16'hffff) ? 16'hffff : h[15:0];
    endfunction : duty_exp
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, e);
        host_model_inst.read(a, got);
        chk(got & m, e);
    endtask : rd_chk
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial
    begin
        #5_000_000;
        num_errors++;
        $display("ERROR %0t: run timed out", $time);
        final_report();
    end
    initial
    begin
        {resetn, tmo, bad, opn, sht, gnd, pwm, chan, st, cfg} = '0;
        seed = 32'h361b12fa;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        for (i = 0; i < 6; i++)
            rd_chk(adt[i], 16'hffff, 16'h0000);
        for (k = 0; k < 20; k++)
        begin
            @(negedge sys_clk);
            {chan, gnd, cfg} = 21'($random(seed));
            st = 5'(k);
            rd_chk(OFS_LED_FAULT, 16'h813f, {7'h0, gnd, 4'h0, chan});
            rd_chk(OFS_STATE_DIAG, 16'hffff, {11'h0, st});
            rd_chk(OFS_PWM_OUT_DIAG, 16'hffff, cfg);
        end
        gnd = 1'b0;
        for (i = 0; i < 5; i++)
        begin
            fb = fbt[i];
            pb = pbt[i];
            host_model_inst.write(OFS_LED_FAULT, 16'h7e30);
            @(negedge sys_clk);
            {tmo, bad, opn, sht, gnd} = 5'b10000 >> i;
            fork
                rd_chk(OFS_LED_FAULT, fb, fb);
                begin
                    @(negedge sys_clk);
                    {tmo, bad, opn, sht, gnd} = '0;
                end
            join
            chk({15'h0, pend}, 16'h0001);
            host_model_inst.write(OFS_LED_FAULT, pb & (pb >> 1));
            host_model_inst.write(OFS_LED_FAULT, pb & ~(pb >> 1));
            rd_chk(OFS_LED_FAULT, fb, fb);
            host_model_inst.write(OFS_LED_FAULT, pb);
            rd_chk(OFS_LED_FAULT, fb, 16'h0000);
            chk({15'h0, pend}, 16'h0000);
        end
        // Event and paired clear on the same edge: the set must win
        fork
            host_model_inst.write(OFS_LED_FAULT, 16'h6000);
            begin
                @(negedge sys_clk);
                tmo = 1'b1;
                @(negedge sys_clk);
                tmo = 1'b0;
            end
        join
        rd_chk(OFS_LED_FAULT, 16'h4000, 16'h4000);
        chk({15'h0, pend}, 16'h0001);
        host_model_inst.write(OFS_LED_FAULT, 16'h6000);
        rd_chk(OFS_LED_FAULT, 16'h4000, 16'h0000);
        chk({15'h0, pend}, 16'h0000);
        for (k = 0; k < 5; k++)
        begin
            for (i = 0; i < 192; i++)
            begin
                @(negedge sys_clk);
                pwm = (i % 4) < k;
            end
            rd_chk(OFS_PWM_IN_DIAG, 16'hffff, duty_exp(k));
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
